// >>> hw/byte_buffer.sv
// two-entry skid buffer with valid and ready on both sides
`timescale 1ns/100ps
module byte_buffer #(
  parameter int WIDTH = 17
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic out_valid_reg;
  logic skid_valid_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic [WIDTH-1:0] skid_data_reg;
  logic take;
  logic drain;

  assign take = in_valid & ~skid_valid_reg;
  assign drain = out_valid_reg & out_ready;
  // ready from a flop only, so the source never sees a combinational loop
  assign in_ready = ~skid_valid_reg;
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_valid_reg <= 1'b0;
      skid_valid_reg <= 1'b0;
      out_data_reg <= '0;
      skid_data_reg <= '0;
    end else begin
      if (!out_valid_reg || drain) begin
        if (skid_valid_reg) begin
          out_data_reg <= skid_data_reg;
          out_valid_reg <= 1'b1;
          skid_valid_reg <= take;
          skid_data_reg <= in_data;
        end else begin
          out_data_reg <= in_data;
          out_valid_reg <= take;
        end
      end else if (take) begin
        skid_valid_reg <= 1'b1;
        skid_data_reg <= in_data;
      end
    end
  end
endmodule

// >>> hw/rtc_twi_consts.svh
// constants of the two-wire target port
`ifndef RTC_TWI_CONSTS_SVH
`define RTC_TWI_CONSTS_SVH

// ----------------------------------------------------------------------
// addresses
// ----------------------------------------------------------------------
`define RTC_OWN_ADDR 7'h51
`define RTC_TEST_BYTE_A 8'h49
`define RTC_TEST_BYTE_B 8'h4A
`define RTC_DIR_BIT 0

// ----------------------------------------------------------------------
// byte framing
// ----------------------------------------------------------------------
`define RTC_LAST_BIT 3'h7
`define RTC_PTR_RESET 8'h00
`define RTC_PTR_STEP 8'h01

`endif

// >>> hw/rtc_twi_pkg.sv
// types shared by the two-wire target port and its testbench
package rtc_twi_pkg;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_ADDR   = 8'h02,
    ST_ACK_TX = 8'h04,
    ST_RX     = 8'h08,
    ST_STALL  = 8'h10,
    ST_TX     = 8'h20,
    ST_ACK_RX = 8'h40,
    ST_WAIT   = 8'h80
  } state_type;

  typedef struct packed {
    logic test;
    logic [7:0] addr;
    logic [7:0] data;
  } wr_word_type;

endpackage

// >>> hw/rtc_two_wire_target_port.sv
// two-wire target port: framing, address match, register pointer
//
// Operation
// - answer own address or a test byte, else release
// - fixed seven-bit address, A2 write A3 read
// - direction in bit 0, one means read
// - write: address, pointer byte, data bytes acknowledged
// - unlimited byte count per transaction
// - test bytes 49 and 4A are answered
// - pointer advances after every data byte
// - receiver drives acknowledge on ninth clock
// - no acknowledge on read: release, await stop
// - start, stop, repeated start from data edges
`timescale 1ns/100ps
`include "rtc_twi_consts.svh"
module rtc_two_wire_target_port (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output rtc_twi_pkg::wr_word_type wr_word,
  output logic test_sel
);
  import rtc_twi_pkg::*;

  // --------------------------------------------------------------------
  // line sampling and bus conditions
  // --------------------------------------------------------------------
  state_type state_reg;
  logic scl_q_reg;
  logic sda_q_reg;
  logic [7:0] shift_reg;
  logic [2:0] cnt_reg;
  logic full_reg;
  logic dir_reg;
  logic after_addr_reg;
  logic have_ptr_reg;
  logic [7:0] ptr_reg;
  logic sda_oe_reg;
  logic scl_oe_reg;
  logic test_sel_reg;
  logic buf_ready;
  logic push;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic data_done;
  logic addr_hit;
  logic test_hit;
  wr_word_type push_word;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl_in;
      sda_q_reg <= sda_in;
    end
  end

  assign scl_rise = scl_in & ~scl_q_reg;
  assign scl_fall = ~scl_in & scl_q_reg;
  assign start_cond = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
  assign stop_cond = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
  assign data_done = scl_fall & full_reg;
  assign addr_hit = shift_reg[7:1] == `RTC_OWN_ADDR;
  assign test_hit = (shift_reg == `RTC_TEST_BYTE_A) | (shift_reg == `RTC_TEST_BYTE_B);
  // a full buffer stalls here by stretching the clock, not by dropping
  assign push = buf_ready & (((state_reg == ST_RX) & data_done & have_ptr_reg)
                | (state_reg == ST_STALL));
  assign push_word = '{test: test_sel_reg, addr: ptr_reg, data: shift_reg};

  // --------------------------------------------------------------------
  // transaction sequencing
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      dir_reg <= 1'b0;
      after_addr_reg <= 1'b0;
      have_ptr_reg <= 1'b0;
      test_sel_reg <= 1'b0;
    end else if (stop_cond) begin
      state_reg <= ST_IDLE;
      test_sel_reg <= 1'b0;
    end else if (start_cond) begin
      state_reg <= ST_ADDR;
      test_sel_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_IDLE;
        end
        ST_ADDR: begin
          if (data_done) begin
            if (addr_hit || test_hit) begin
              state_reg <= ST_ACK_TX;
              dir_reg <= shift_reg[`RTC_DIR_BIT];
              after_addr_reg <= 1'b1;
              test_sel_reg <= test_hit;
            end else begin
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_ACK_TX: begin
          if (scl_fall) begin
            after_addr_reg <= 1'b0;
            if (after_addr_reg && dir_reg) begin
              state_reg <= ST_TX;
            end else begin
              state_reg <= ST_RX;
              if (after_addr_reg) begin
                have_ptr_reg <= 1'b0;
              end
            end
          end
        end
        ST_RX: begin
          if (data_done) begin
            if (!have_ptr_reg) begin
              have_ptr_reg <= 1'b1;
              state_reg <= ST_ACK_TX;
            end else begin
              state_reg <= buf_ready ? ST_ACK_TX : ST_STALL;
            end
          end
        end
        ST_STALL: begin
          if (buf_ready) begin
            state_reg <= ST_ACK_TX;
          end
        end
        ST_TX: begin
          if (scl_fall && cnt_reg == `RTC_LAST_BIT) begin
            state_reg <= ST_ACK_RX;
          end
        end
        ST_ACK_RX: begin
          if (scl_rise && sda_in) begin
            state_reg <= ST_WAIT;
          end else if (scl_fall) begin
            state_reg <= ST_TX;
          end
        end
        ST_WAIT: begin
          state_reg <= ST_WAIT;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // shift register and bit count
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shift_reg <= 8'h00;
      cnt_reg <= 3'h0;
      full_reg <= 1'b0;
    end else if (start_cond || (state_reg == ST_ACK_TX && scl_fall && !(after_addr_reg
                 && dir_reg))) begin
      cnt_reg <= 3'h0;
      full_reg <= 1'b0;
    end else if ((state_reg == ST_ADDR || state_reg == ST_RX) && scl_rise) begin
      shift_reg <= {shift_reg[6:0], sda_in};
      cnt_reg <= cnt_reg + 3'h1;
      full_reg <= cnt_reg == `RTC_LAST_BIT;
    end else if ((state_reg == ST_ACK_TX || state_reg == ST_ACK_RX) && scl_fall) begin
      // next read byte goes out on the fall that ends the acknowledge
      shift_reg <= rd_data;
      cnt_reg <= 3'h0;
      full_reg <= 1'b0;
    end else if (state_reg == ST_TX && scl_fall) begin
      shift_reg <= {shift_reg[6:0], 1'b1};
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  // --------------------------------------------------------------------
  // register pointer
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ptr_reg <= `RTC_PTR_RESET;
    end else if (state_reg == ST_RX && data_done && !have_ptr_reg) begin
      ptr_reg <= shift_reg;
    end else if (push || (state_reg == ST_TX && scl_fall && cnt_reg == `RTC_LAST_BIT)) begin
      ptr_reg <= ptr_reg + `RTC_PTR_STEP;
    end
  end

  // --------------------------------------------------------------------
  // pin drivers, open drain: only ever pull low
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
    end else begin
      sda_oe_reg <= (state_reg == ST_ACK_TX) | ((state_reg == ST_TX) & ~shift_reg[7]);
      scl_oe_reg <= (state_reg == ST_STALL) | (scl_oe_reg & ~sda_oe_reg);
    end
  end

  assign sda_oe = sda_oe_reg;
  assign scl_oe = scl_oe_reg;
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign rd_addr = ptr_reg;
  assign test_sel = test_sel_reg;

  // --------------------------------------------------------------------
  // write buffer toward the register file
  // --------------------------------------------------------------------
  byte_buffer #(
    .WIDTH($bits(wr_word_type))
  ) u_wr_buffer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data(push_word),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_addr_done;
    (state_reg == ST_ADDR) && data_done && !start_cond && !stop_cond;
  endsequence

  property p_stop_idle;
    stop_cond |=> state_reg == ST_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not idle");

  property p_start_addr;
    start_cond && !stop_cond |=> state_reg == ST_ADDR && cnt_reg == 3'h0;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not seen");

  property p_mismatch_release;
    s_addr_done ##0 (!addr_hit && !test_hit) |=> state_reg == ST_WAIT ##1 !sda_oe_reg;
  endproperty
  a_mismatch_release: assert property (p_mismatch_release) else $error("foreign addr");

  property p_own_ack;
    s_addr_done ##0 addr_hit |=> state_reg == ST_ACK_TX ##1 sda_oe_reg;
  endproperty
  a_own_ack: assert property (p_own_ack) else $error("own addr not acked");

  property p_test_ack;
    s_addr_done ##0 test_hit |=> test_sel_reg && state_reg == ST_ACK_TX;
  endproperty
  a_test_ack: assert property (p_test_ack) else $error("test byte not acked");

  property p_ptr_step;
    push |=> ptr_reg == 8'($past(ptr_reg) + `RTC_PTR_STEP);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer not advanced");

  property p_nack_release;
    state_reg == ST_ACK_RX && scl_rise && sda_in && !stop_cond && !start_cond
      |=> state_reg == ST_WAIT ##1 !sda_oe_reg;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("nack not released");

  property p_read_dir;
    state_reg == ST_ACK_TX && scl_fall && after_addr_reg && dir_reg && !stop_cond
      && !start_cond |=> state_reg == ST_TX;
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("read not entered");

  property p_first_ptr;
    state_reg == ST_RX && data_done && !have_ptr_reg && !start_cond && !stop_cond
      |=> ptr_reg == $past(shift_reg) && have_ptr_reg;
  endproperty
  a_first_ptr: assert property (p_first_ptr) else $error("pointer byte lost");
endmodule

// >>> test/test_rtc_two_wire_target_port.sv
// self-checking bench of the two-wire target port
`timescale 1ns/100ps
module test_rtc_two_wire_target_port;
  import rtc_twi_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_ready = 1'b0;
  logic stall = 1'b0;
  logic stretched = 1'b0;
  logic last_test = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic scl_out, scl_oe, sda_out, sda_oe, wr_valid, test_sel, c_scl_oe, c_sda_oe, hung, ack_n;
  logic [7:0] rd_addr, q, p, a;
  int n;
  wr_word_type wr_word;
  logic [7:0] mem [256];
  logic [7:0] exp_mem [256];
  integer seed = 32'h3C09A62C;
  int errors = 0;
  int total_checks = 0;
  // pull-ups: a released line reads high
  wire scl = ~c_scl_oe & (scl_oe ? scl_out : 1'b1);
  wire sda = ~c_sda_oe & (sda_oe ? sda_out : 1'b1);
  rtc_two_wire_target_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_word(wr_word), .test_sel(test_sel));
  twi_bus_ctl c (.sys_clk(sys_clk), .scl(scl), .sda(sda), .scl_oe(c_scl_oe),
    .sda_oe(c_sda_oe), .hung(hung));
  always #5 sys_clk = ~sys_clk;
  // register file stand-in with a randomly stalling write side
  always @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
    wr_ready <= ~stall & 1'($random(seed));
    if (scl_oe) stretched <= 1'b1;
    if (wr_valid && wr_ready) begin
      mem[wr_word.addr] <= wr_word.data;
      last_test <= wr_word.test;
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // pointer expected after k bytes from a start value, wrapping at the top
  function automatic logic [7:0] ptr_after(input logic [7:0] ptr, input int k);
    return 8'(ptr + k);
  endfunction
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_txn(input logic [7:0] first, input logic [7:0] ptr, input int k);
    logic [7:0] d;
    c.start();
    c.xfer(first, 1'b1, q, ack_n);
    check("addr ack", ack_n, 1'b0);
    c.xfer(ptr, 1'b1, q, ack_n);
    check("ptr ack", ack_n, 1'b0);
    for (int i = 0; i < k; i++) begin
      d = 8'($random(seed));
      exp_mem[ptr_after(ptr, i)] = d;
      c.xfer(d, 1'b1, q, ack_n);
      check("data ack", ack_n, 1'b0);
    end
    c.stop();
    check("ptr after write", rd_addr, ptr_after(ptr, k));
  endtask
  task automatic rd_bytes(input logic [7:0] ptr, input int k);
    for (int i = 0; i < k; i++) begin
      c.xfer(8'hFF, i == k - 1, q, ack_n);
      check("read data", q, exp_mem[ptr_after(ptr, i)]);
    end
    check("released", sda_oe, 1'b0);
    c.stop();
  endtask
  task automatic std_read(input logic [7:0] ptr, input int k);
    c.start();
    c.xfer(8'hA2, 1'b1, q, ack_n);
    c.xfer(ptr, 1'b1, q, ack_n);
    c.start();
    c.xfer(8'hA3, 1'b1, q, ack_n);
    check("read ack", ack_n, 1'b0);
    rd_bytes(ptr, k);
  endtask
  task automatic drain();
    int k = 0;
    while (wr_valid && k < 2000) begin
      @(posedge sys_clk);
      k++;
    end
    if (wr_valid) begin
      errors++;
      tally_and_finish();
    end
  endtask
  always @(posedge hung) begin
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($random(seed));
      exp_mem[i] = mem[i];
    end
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("reset", {sda_oe, scl_oe, wr_valid, test_sel, rd_addr}, 12'h000);
    for (int r = 0; r < 6; r++) begin
      p = 8'($random(seed));
      n = 1 + $unsigned($random(seed)) % 6;
      wr_txn(8'hA2, p, n);
      std_read(p, n);
    end
    $display("test random rounds done");
    // partial byte is dropped, pointer stays
    c.start();
    c.xfer(8'hA2, 1'b1, q, ack_n);
    for (int i = 0; i < 4; i++) c.bit_io(1'b0, ack_n);
    c.start();
    c.xfer(8'hA3, 1'b1, q, ack_n);
    rd_bytes(ptr_after(p, n), 2);
    wr_txn(8'hA2, 8'hFE, 4);
    c.start();
    c.xfer(8'hA3, 1'b1, q, ack_n);
    check("simple ack", ack_n, 1'b0);
    rd_bytes(8'h02, 3);
    std_read(8'hFE, 4);
    $display("test wrap and restart done");
    stall <= 1'b1;
    fork
      begin
        repeat (800) @(posedge sys_clk);
        stall <= 1'b0;
      end
    join_none
    p = 8'($random(seed));
    wr_txn(8'hA2, p, 20);
    check("stretch", stretched, 1'b1);
    std_read(p, 20);
    $display("test long burst done");
    for (int i = 0; i < 4; i++) begin
      do a = 8'($random(seed)); while (a inside {8'hA2, 8'hA3, 8'h49, 8'h4A});
      c.start();
      c.xfer(a, 1'b1, q, ack_n);
      check("foreign nack", ack_n, 1'b1);
      c.xfer(8'h00, 1'b1, q, ack_n);
      check("ignored nack", ack_n, 1'b1);
      c.stop();
    end
    check("ptr kept", rd_addr, ptr_after(p, 20));
    wr_txn(8'h4A, 8'h10, 2);
    drain();
    check("test word", last_test, 1'b1);
    c.start();
    c.xfer(8'h49, 1'b1, q, ack_n);
    check("test ack", {ack_n, test_sel}, 2'b01);
    c.xfer(8'hFF, 1'b1, q, ack_n);
    c.stop();
    wr_txn(8'hA2, 8'h20, 1);
    drain();
    check("plain word", last_test, 1'b0);
    $display("test addressing done");
    for (int i = 0; i < 256; i++) check("reg file", mem[i], exp_mem[i]);
    tally_and_finish();
  end
endmodule

// >>> test/twi_bus_ctl.sv
// bus controller model: drives clock and data as open drain
`timescale 1ns/100ps
module twi_bus_ctl (
  input wire logic sys_clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe,
  output logic hung
);
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    hung = 1'b0;
  end
  // four cycles keep each clock phase above the three-cycle minimum
  task automatic gap();
    repeat (4) @(posedge sys_clk);
  endtask
  // target may stretch the clock: wait for the line, bounded
  task automatic rise();
    int k = 0;
    scl_oe <= 1'b0;
    @(posedge sys_clk);
    while (!scl && k < 3000) begin
      @(posedge sys_clk);
      k++;
    end
    if (!scl) hung <= 1'b1;
    gap();
  endtask
  task automatic start();
    sda_oe <= 1'b0;
    gap();
    rise();
    sda_oe <= 1'b1;
    gap();
    scl_oe <= 1'b1;
    gap();
  endtask
  task automatic stop();
    sda_oe <= 1'b1;
    gap();
    rise();
    sda_oe <= 1'b0;
    gap();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_oe <= ~b;
    gap();
    rise();
    r = sda;
    scl_oe <= 1'b1;
    gap();
  endtask
  // ninth bit is the acknowledge of whoever received
  task automatic xfer(input logic [7:0] d, input logic ninth, output logic [7:0] q,
    output logic ack_n);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ninth, ack_n);
  endtask
endmodule
